// file: smh_regs.vh
// Constants of the storage host port: modes, widths, framing, timing.
// Assumes inclusion by bare name from the design files of this folder.
`ifndef SMH_REGS_VH
`define SMH_REGS_VH
`define SMH_MODE_SD        2'h0
`define SMH_MODE_MMC       2'h1
`define SMH_MODE_SDIO      2'h2
`define SMH_WID_1          2'h0
`define SMH_WID_4          2'h1
`define SMH_WID_8          2'h2
`define SMH_DET_NONE       2'h0
`define SMH_DET_DAT3       2'h1
`define SMH_DET_SWITCH     2'h2
`define SMH_CMD_BITS       48
`define SMH_RSP_BITS       48
`define SMH_CLK_DIV        4
`define SMH_FIFO_DEPTH     8
`define SMH_BLK_BYTES      16
`define SMH_RSP_TIMEOUT    255
`endif

// file: smh_fifo.v
// Small FIFO with parameter width and depth, valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module smh_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_in,
    input  wire             rst_n_in,
    input  wire [WIDTH-1:0] wr_data_in,
    input  wire             wr_valid_in,
    output reg              wr_ready_out,
    output reg  [WIDTH-1:0] rd_data_out,
    output reg              rd_valid_out,
    input  wire             rd_ready_in
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      count;
    reg [AW-1:0]    wp;
    reg [AW-1:0]    rp;
    wire            push;
    wire            pop;
    wire            load;
    wire            take;
    wire [AW:0]     occ;
    // Occupancy counts the output register, so DEPTH words fill the FIFO
    assign take = rd_valid_out && rd_ready_in;
    assign occ  = count + {{AW{1'b0}}, rd_valid_out};
    assign push = wr_valid_in && wr_ready_out;
    assign load = (count != {(AW+1){1'b0}}) && (!rd_valid_out || rd_ready_in);
    assign pop  = load;
    always @(posedge clk_in) begin
        if (push) begin
            mem[wp] <= wr_data_in;
        end
    end
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            count        <= {(AW+1){1'b0}};
            wp           <= {AW{1'b0}};
            rp           <= {AW{1'b0}};
            rd_valid_out <= 1'b0;
            rd_data_out  <= {WIDTH{1'b0}};
            wr_ready_out <= 1'b1;
        end else begin
            if (push) begin
                wp <= wp + 1'b1;
            end
            if (pop) begin
                rp          <= rp + 1'b1;
                rd_data_out <= mem[rp];
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
            // Registered ready: next occupancy against the depth
            wr_ready_out <= (occ + {{AW{1'b0}}, push}
                             - {{AW{1'b0}}, take}) != DEPTH[AW:0];
            if (pop) begin
                rd_valid_out <= 1'b1;
            end else if (rd_ready_in) begin
                rd_valid_out <= 1'b0;
            end
        end
    end
endmodule // smh_fifo
`default_nettype wire

// file: smh_host_port.v
// Storage host port: card clock, command/response line, 1/4/8-bit data.
// Assumes pins pass through a pad ring resolving the three-signal triplets.
`timescale 1ns/10ps
`default_nettype none
`include "smh_regs.vh"
module smh_host_port #(
    parameter CMD_BITS = `SMH_CMD_BITS,
    parameter RSP_BITS = `SMH_RSP_BITS,
    parameter CLK_DIV  = `SMH_CLK_DIV,
    parameter BLK      = `SMH_BLK_BYTES,
    parameter RSP_TO   = `SMH_RSP_TIMEOUT
) (
    input  wire        clk_in,
    input  wire        rst_n_in,
    input  wire        pin_matrix_select_in,
    input  wire [1:0]  mode_in,
    input  wire [1:0]  width_in,
    input  wire [1:0]  card_detect_kind_in,
    input  wire        socket_switch_in,
    input  wire        cmd_start_in,
    input  wire [37:0] cmd_word_in,
    input  wire        cmd_resp_in,
    input  wire        data_read_in,
    input  wire        data_write_in,
    input  wire [7:0]  wr_data_in,
    input  wire        wr_valid_in,
    output wire        wr_ready_out,
    output wire [7:0]  rd_data_out,
    output wire        rd_valid_out,
    input  wire        rd_ready_in,
    output reg  [39:0] resp_out,
    output reg         busy_out,
    output reg         done_out,
    output reg         timeout_out,
    output reg         card_event_out,
    output reg         card_present_out,
    output reg         card_clk_out,
    input  wire        cmd_line_in,
    output reg         cmd_line_out,
    output reg         cmd_oe_n_out,
    input  wire [7:0]  dat_line_in,
    output reg  [7:0]  dat_line_out,
    output reg  [7:0]  dat_oe_n_out
);
    // ****************************************
    // States and pin synchronisers
    // ****************************************
    localparam ST_IDLE = 6'h01, ST_CMD = 6'h02, ST_WAIT = 6'h04;
    localparam ST_RSP  = 6'h08, ST_RD  = 6'h10, ST_WR   = 6'h20;
    reg  [5:0]  state;
    reg  [1:0]  cmd_s;
    reg  [15:0] dat_s0;
    reg  [7:0]  dat_s;
    reg  [1:0]  sw_s;
    reg  [7:0]  div;
    reg  [47:0] sh;
    reg  [7:0]  cnt;
    reg  [7:0]  bytes;
    reg  [7:0]  rbyte;
    reg         rvalid;
    reg  [1:0]  wid;
    reg         pres_q;
    wire        tick_fall;
    wire        tick_rise;
    wire        in_rdy;
    wire        wv;
    wire [7:0]  wd;
    wire        det;
    wire [3:0]  lanes;
    wire [7:0]  wsrc;
    wire [7:0]  wleft;
    integer     i;
    always @(posedge clk_in) begin
        cmd_s  <= {cmd_s[0], cmd_line_in};
        dat_s0 <= {dat_s0[7:0], dat_line_in};
        dat_s  <= dat_s0[15:8];
        sw_s   <= {sw_s[0], socket_switch_in};
    end
    // Width clamped per mode so a bad setting never widens the bus
    always @* begin
        wid = `SMH_WID_1;
        if (width_in == `SMH_WID_8 && mode_in == `SMH_MODE_MMC) begin
            wid = `SMH_WID_8;
        end else if (width_in != `SMH_WID_1) begin
            wid = `SMH_WID_4;
        end
    end
    assign lanes = (wid == `SMH_WID_8) ? 4'h8 :
                   (wid == `SMH_WID_4) ? 4'h4 : 4'h1;
    // ****************************************
    // Card clock divider
    // ****************************************
    assign tick_rise = (div == (CLK_DIV/2 - 1)) && !card_clk_out;
    assign tick_fall = (div == (CLK_DIV/2 - 1)) && card_clk_out;
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            div          <= 8'h00;
            card_clk_out <= 1'b0;
        end else if (div == (CLK_DIV/2 - 1)) begin
            div          <= 8'h00;
            card_clk_out <= !card_clk_out;
        end else begin
            div <= div + 8'h01;
        end
    end
    // ****************************************
    // Write data buffer
    // ****************************************
    smh_fifo #(.WIDTH(8), .DEPTH(`SMH_FIFO_DEPTH), .AW(3)) u_wbuf (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .wr_data_in   (wr_data_in),
        .wr_valid_in  (wr_valid_in),
        .wr_ready_out (wr_ready_out),
        .rd_data_out  (wd),
        .rd_valid_out (wv),
        .rd_ready_in  (in_rdy)
    );
    assign in_rdy = (state == ST_WR) && tick_fall && (cnt == 8'h00)
                    && (bytes != 8'h00) && (bytes != BLK[7:0] + 8'h01)
                    && wv;
    assign rd_data_out  = rbyte;
    assign rd_valid_out = rvalid;
    // Next write group comes straight from the buffer at a byte boundary
    assign wsrc  = (cnt == 8'h00) ? wd : sh[7:0];
    assign wleft = (cnt == 8'h00) ? 8'h08 : cnt;
    // ****************************************
    // Card detect
    // ****************************************
    assign det = (card_detect_kind_in == `SMH_DET_DAT3) ? dat_s[3] :
                 (card_detect_kind_in == `SMH_DET_SWITCH) ? !sw_s[1] :
                 1'b0;
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            pres_q           <= 1'b0;
            card_present_out <= 1'b0;
            card_event_out   <= 1'b0;
        end else begin
            // Line 3 carries data when busy, so its level is held then
            if (state == ST_IDLE || card_detect_kind_in != `SMH_DET_DAT3) begin
                pres_q <= det;
            end
            card_present_out <= pres_q;
            // Only the selected kind may raise an event
            card_event_out   <= (card_detect_kind_in != `SMH_DET_NONE)
                                && (pres_q != card_present_out);
        end
    end
    // ****************************************
    // Command, response and data engine
    // ****************************************
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            state        <= ST_IDLE;
            sh           <= 48'h000000000000;
            cnt          <= 8'h00;
            bytes        <= 8'h00;
            rbyte        <= 8'h00;
            rvalid       <= 1'b0;
            resp_out     <= 40'h0000000000;
            busy_out     <= 1'b0;
            done_out     <= 1'b0;
            timeout_out  <= 1'b0;
            cmd_line_out <= 1'b1;
            cmd_oe_n_out <= 1'b1;
            dat_line_out <= 8'hFF;
            dat_oe_n_out <= 8'hFF;
        end else begin
            done_out    <= 1'b0;
            timeout_out <= 1'b0;
            if (rvalid && rd_ready_in) begin
                rvalid <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    // Port takes no command until pins are routed to it; the card clock runs regardless
                    if (cmd_start_in && pin_matrix_select_in) begin
                        sh       <= {2'b01, cmd_word_in, 8'h01};
                        cnt      <= CMD_BITS[7:0];
                        busy_out <= 1'b1;
                        state    <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (tick_fall) begin
                        if (cnt == 8'h00) begin
                            cmd_oe_n_out <= 1'b1;
                            cmd_line_out <= 1'b1;
                            cnt          <= RSP_TO[7:0];
                            state        <= cmd_resp_in ? ST_WAIT : ST_IDLE;
                            busy_out     <= cmd_resp_in;
                            done_out     <= !cmd_resp_in;
                        end else begin
                            cmd_oe_n_out <= 1'b0;
                            cmd_line_out <= sh[47];
                            sh           <= {sh[46:0], 1'b1};
                            cnt          <= cnt - 8'h01;
                        end
                    end
                end
                ST_WAIT: begin
                    if (tick_rise) begin
                        if (!cmd_s[1]) begin
                            cnt   <= RSP_BITS[7:0] - 8'h01;
                            state <= ST_RSP;
                        end else if (cnt == 8'h00) begin
                            timeout_out <= 1'b1;
                            busy_out    <= 1'b0;
                            state       <= ST_IDLE;
                        end else begin
                            cnt <= cnt - 8'h01;
                        end
                    end
                end
                ST_RSP: begin
                    if (tick_rise) begin
                        sh  <= {sh[46:0], cmd_s[1]};
                        cnt <= cnt - 8'h01;
                        if (cnt == 8'h01) begin
                            resp_out <= {sh[38:0], cmd_s[1]};
                            bytes    <= 8'h00;
                            cnt      <= RSP_TO[7:0];
                            if (data_read_in) begin
                                state <= ST_RD;
                            end else if (data_write_in) begin
                                state <= ST_WR;
                                cnt   <= 8'h00;
                            end else begin
                                busy_out <= 1'b0;
                                done_out <= 1'b1;
                                state    <= ST_IDLE;
                            end
                        end
                    end
                end
                ST_RD: begin
                    // Start bit on line 0, then bytes across active lanes
                    if (tick_rise) begin
                        if (bytes == 8'h00) begin
                            if (!dat_s[0]) begin
                                bytes <= 8'h01;
                                cnt   <= 8'h00;
                            end
                        end else if (bytes == BLK[7:0] + 8'h01) begin
                            busy_out <= 1'b0;
                            done_out <= 1'b1;
                            state    <= ST_IDLE;
                        end else begin
                            if (wid == `SMH_WID_8) begin
                                sh[7:0] <= dat_s;
                            end else if (wid == `SMH_WID_4) begin
                                sh[7:0] <= {sh[3:0], dat_s[3:0]};
                            end else begin
                                sh[7:0] <= {sh[6:0], dat_s[0]};
                            end
                            if (cnt + {4'h0, lanes} >= 8'h08) begin
                                cnt   <= 8'h00;
                                bytes <= bytes + 8'h01;
                                rvalid <= 1'b1;
                                if (wid == `SMH_WID_8) begin
                                    rbyte <= dat_s;
                                end else if (wid == `SMH_WID_4) begin
                                    rbyte <= {sh[3:0], dat_s[3:0]};
                                end else begin
                                    rbyte <= {sh[6:0], dat_s[0]};
                                end
                            end else begin
                                cnt <= cnt + {4'h0, lanes};
                            end
                        end
                    end
                end
                ST_WR: begin
                    if (tick_fall) begin
                        if (bytes == 8'h00) begin
                            for (i = 0; i < 8; i = i + 1) begin
                                dat_oe_n_out[i] <= (i >= lanes);
                            end
                            dat_line_out <= 8'h00;
                            bytes        <= 8'h01;
                        end else if (bytes == BLK[7:0] + 8'h01) begin
                            if (dat_oe_n_out == 8'hFF) begin
                                busy_out <= 1'b0;
                                done_out <= 1'b1;
                                state    <= ST_IDLE;
                            end
                            dat_line_out <= 8'hFF;
                            dat_oe_n_out <= 8'hFF;
                        end else if (cnt != 8'h00 || wv) begin
                            // Empty buffer stretches the bit; clock runs on
                            if (wid == `SMH_WID_8) begin
                                dat_line_out <= wsrc;
                                sh[7:0]      <= 8'h00;
                            end else if (wid == `SMH_WID_4) begin
                                dat_line_out <= {4'hF, wsrc[7:4]};
                                sh[7:0]      <= {wsrc[3:0], 4'h0};
                            end else begin
                                dat_line_out <= {7'h7F, wsrc[7]};
                                sh[7:0]      <= {wsrc[6:0], 1'b0};
                            end
                            cnt <= wleft - {4'h0, lanes};
                            if (wleft == {4'h0, lanes}) begin
                                bytes <= bytes + 8'h01;
                            end
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // smh_host_port
`default_nettype wire

// file: smh_host_port_assertions.sv
// Concurrent checks on the storage host port's pins and handshakes.
// Assumes binding onto smh_host_port; sees its ports and nothing else.
`timescale 1ns/10ps
`default_nettype none
`include "smh_regs.vh"
module smh_host_port_assertions (
    input wire logic       clk_in,
    input wire logic       rst_n_in,
    input wire logic       pin_matrix_select_in,
    input wire logic [1:0] mode_in,
    input wire logic [1:0] width_in,
    input wire logic [1:0] card_detect_kind_in,
    input wire logic       cmd_start_in,
    input wire logic       busy_out,
    input wire logic       done_out,
    input wire logic       timeout_out,
    input wire logic       card_event_out,
    input wire logic       rd_valid_out,
    input wire logic       card_clk_out,
    input wire logic       cmd_line_out,
    input wire logic       cmd_oe_n_out,
    input wire logic [7:0] dat_oe_n_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    a_clk_high_phase: assert property ($rose(card_clk_out) |=>
        card_clk_out ##1 !card_clk_out) else $error("card clock phase");
    a_cmd_on_low: assert property (!cmd_oe_n_out &&
        $changed(cmd_line_out) |-> !card_clk_out) else $error("cmd edge");
    a_cmd_start_bit: assert property ($fell(cmd_oe_n_out) |->
        !cmd_line_out) else $error("command start bit not low");
    a_cmd_stop_bit: assert property ($rose(cmd_oe_n_out) |->
        $past(cmd_line_out)) else $error("command end bit not high");
    a_start_taken: assert property (cmd_start_in &&
        pin_matrix_select_in && !busy_out |=> busy_out) else $error("start");
    a_start_refused: assert property (!pin_matrix_select_in &&
        !busy_out |=> !busy_out) else $error("start taken unselected");
    a_idle_dat_free: assert property (!busy_out &&
        !$past(busy_out) |-> dat_oe_n_out == 8'hFF) else $error("dat held");
    a_width_one: assert property (busy_out &&
        width_in == `SMH_WID_1 |-> &dat_oe_n_out[7:1]) else $error("lane");
    a_no_wide_bus: assert property (busy_out &&
        mode_in != `SMH_MODE_MMC |-> &dat_oe_n_out[7:4]) else $error("wide");
    a_event_gated: assert property (card_detect_kind_in == 2'h0 &&
        $past(card_detect_kind_in) == 2'h0 |-> !card_event_out)
        else $error("event without detect kind");
    c_done: cover property (done_out);
    c_timeout: cover property (timeout_out);
    c_event: cover property (card_event_out);
    c_read: cover property (rd_valid_out);
endmodule // smh_host_port_assertions
bind smh_host_port smh_host_port_assertions i_chk (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .pin_matrix_select_in(pin_matrix_select_in),
    .mode_in(mode_in), .width_in(width_in), .cmd_start_in(cmd_start_in),
    .card_detect_kind_in(card_detect_kind_in), .busy_out(busy_out),
    .done_out(done_out), .timeout_out(timeout_out),
    .card_event_out(card_event_out), .rd_valid_out(rd_valid_out),
    .card_clk_out(card_clk_out), .cmd_line_out(cmd_line_out),
    .cmd_oe_n_out(cmd_oe_n_out), .dat_oe_n_out(dat_oe_n_out));
`default_nettype wire

// file: smh_card_model.sv
// Behavioural card on the far side: takes commands, answers, moves data.
// Assumes the bench resolves shared lines with pull-ups when released.
`timescale 1ns/10ps
`default_nettype none
`include "smh_regs.vh"
module smh_card_model (
    input  wire logic         card_clk_in,
    input  wire logic         cmd_in,
    input  wire logic [7:0]   dat_in,
    input  wire logic [1:0]   width_in,
    input  wire logic [3:0]   dly_in,
    input  wire logic         resp_en_in,
    input  wire logic         read_en_in,
    input  wire logic         write_en_in,
    input  wire logic [47:0]  resp_in,
    input  wire logic [127:0] blk_in,
    output logic              cmd_drv_out,
    output logic              cmd_val_out,
    output logic [7:0]        dat_drv_out,
    output logic [7:0]        dat_val_out,
    output logic [47:0]       cmd_got_out,
    output logic [127:0]      wr_got_out
);
    int i, k, n;
    initial begin
        cmd_drv_out = 0; cmd_val_out = 1; dat_drv_out = 0; dat_val_out = 0;
        cmd_got_out = 0; wr_got_out = 0;
        forever begin
            @(posedge card_clk_in);
            if (cmd_in === 1'b0) begin
                cmd_got_out[47] = 1'b0;
                for (i = 46; i >= 0; i--) begin
                    @(posedge card_clk_in);
                    cmd_got_out[i] = cmd_in;
                end
                // Lane count follows the width setting alone; the mode is not seen here
                n = width_in == `SMH_WID_8 ? 8 : width_in == `SMH_WID_4 ? 4 : 1;
                if (resp_en_in) begin
                    repeat (dly_in) @(posedge card_clk_in);
                    @(negedge card_clk_in);
                    cmd_drv_out = 1;
                    for (i = 47; i >= 0; i--) begin
                        cmd_val_out = resp_in[i];
                        @(negedge card_clk_in);
                    end
                    cmd_drv_out = 0;
                end
                if (resp_en_in && read_en_in) begin
                    repeat (dly_in) @(negedge card_clk_in);
                    dat_drv_out = 8'((1 << n) - 1);
                    dat_val_out = 8'h00;
                    for (i = 127; i >= 0; i -= n) begin
                        @(negedge card_clk_in);
                        for (k = 0; k < n; k++) dat_val_out[n-1-k] = blk_in[i-k];
                    end
                    @(negedge card_clk_in);
                    dat_val_out = 8'hFF;
                    @(negedge card_clk_in);
                    dat_drv_out = 8'h00;
                end
                if (write_en_in) begin
                    // Skip the edge ending the response; start may share it
                    @(posedge card_clk_in);
                    for (k = 0; k < 1000 && dat_in[0] !== 1'b0; k++)
                        @(posedge card_clk_in);
                    for (i = 127; i >= 0; i -= n) begin
                        @(posedge card_clk_in);
                        for (k = 0; k < n; k++) wr_got_out[i-k] = dat_in[n-1-k];
                    end
                end
            end
        end
    end
endmodule // smh_card_model
`default_nettype wire

// file: smh_testbench.sv
// Self-checking bench for the storage host port with a behavioural card.
// Assumes 40 MHz core clock; card lines carry pull-ups when released.
`timescale 1ns/10ps
`default_nettype none
`include "smh_regs.vh"
module testbench;
    logic         clk_in, rst_n_in, pin_sel, sw, start, rsp, rd, wr, m_rsp;
    logic         wr_valid, rd_ready, wr_ready, rd_valid, busy, done, tmo;
    logic         ev, present, cclk, cmd_out, cmd_oe_n, cmd_w, cmd_val;
    logic         cmd_drv, got_d, got_t, got_e;
    logic [1:0]   mode, width, kind;
    logic [3:0]   dly;
    logic [7:0]   wr_data, rd_data, dat_out, dat_oe_n, dat_w, dat_val, dat_drv;
    logic [37:0]  word;
    logic [39:0]  resp_got;
    logic [47:0]  resp, cmd_got;
    logic [127:0] blk, wr_got;
    logic [1:0]   md_tab [4] = '{`SMH_MODE_SD, `SMH_MODE_SD,
                                 `SMH_MODE_MMC, `SMH_MODE_SDIO};
    logic [1:0]   wd_tab [4] = '{`SMH_WID_1, `SMH_WID_4,
                                 `SMH_WID_8, `SMH_WID_4};
    logic [7:0]   rd_q [$];
    int           n_fail, checks, wr_idx, k, j;
    // Released lines float high through the socket pull-ups
    assign cmd_w = !cmd_oe_n ? cmd_out : cmd_drv ? cmd_val : 1'b1;
    assign dat_w = (~dat_oe_n & dat_out) | (dat_oe_n & ~(dat_drv & ~dat_val));
    smh_host_port i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .pin_matrix_select_in(pin_sel), .mode_in(mode), .width_in(width),
        .card_detect_kind_in(kind), .socket_switch_in(sw),
        .cmd_start_in(start), .cmd_word_in(word), .cmd_resp_in(rsp),
        .data_read_in(rd), .data_write_in(wr), .wr_data_in(wr_data),
        .wr_valid_in(wr_valid), .wr_ready_out(wr_ready),
        .rd_data_out(rd_data), .rd_valid_out(rd_valid),
        .rd_ready_in(rd_ready), .resp_out(resp_got), .busy_out(busy),
        .done_out(done), .timeout_out(tmo), .card_event_out(ev),
        .card_present_out(present), .card_clk_out(cclk),
        .cmd_line_in(cmd_w), .cmd_line_out(cmd_out), .cmd_oe_n_out(cmd_oe_n),
        .dat_line_in(dat_w), .dat_line_out(dat_out), .dat_oe_n_out(dat_oe_n));
    smh_card_model i_card (.card_clk_in(cclk), .cmd_in(cmd_w), .dat_in(dat_w),
        .width_in(width), .dly_in(dly), .resp_en_in(m_rsp), .read_en_in(rd),
        .write_en_in(wr), .resp_in(resp), .blk_in(blk),
        .cmd_drv_out(cmd_drv), .cmd_val_out(cmd_val), .dat_drv_out(dat_drv),
        .dat_val_out(dat_val), .cmd_got_out(cmd_got), .wr_got_out(wr_got));
    initial begin
        clk_in = 0;
        forever #12.5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        if (rd_valid && rd_ready) rd_q.push_back(rd_data);
        if (wr_valid && wr_ready) wr_idx++;
    end
    // Reader stalls one cycle at most: read bytes have no back-pressure
    always @(negedge clk_in) begin
        rd_ready <= !rd_ready || ($urandom % 4) != 0;
        wr_valid <= wr_idx < 16;
        wr_data <= blk[8*(15-wr_idx) +: 8];
    end
    task chk(input logic [127:0] e, input logic [127:0] g);
        checks++;
        if (e !== g) begin
            n_fail++;
            $display("Error at %0t: got %0h expected %0h", $time, g, e);
        end
    endtask
    task stop_test;
        if (n_fail == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task op(input logic [1:0] md, input logic [1:0] wd, input logic r,
            input logic drd, input logic dwr, input logic mr);
        @(negedge clk_in);
        mode = md; width = wd; rsp = r; rd = drd; wr = dwr; m_rsp = mr;
        start = 1;
        @(negedge clk_in);
        start = 0;
        chk(1, busy);
        got_d = 0;
        got_t = 0;
        for (j = 0; j < 5000 && !got_d && !got_t; j++) begin
            @(posedge clk_in);
            #1 got_d = done === 1'b1;
            got_t = tmo === 1'b1;
        end
        if (!got_d && !got_t) begin
            n_fail++;
            $display("Error at %0t: operation never ended", $time);
            stop_test;
        end
    endtask
    task watch_event;
        got_e = 0;
        repeat (10) begin
            @(posedge clk_in);
            #1 got_e = got_e | (ev === 1'b1);
        end
    endtask
    initial begin
        void'($urandom(20));
        rst_n_in = 0; pin_sel = 1; sw = 1; start = 0; rsp = 0; rd = 0; wr = 0;
        mode = 0; width = 0; kind = 0; word = 0; m_rsp = 0; dly = 2;
        blk = 0; resp = 0; n_fail = 0; checks = 0; wr_idx = 16;
        rd_ready = 1; wr_valid = 0; wr_data = 0;
        repeat (10) @(negedge clk_in);
        rst_n_in = 1;
        @(negedge clk_in);
        chk(1, cmd_oe_n);
        chk(8'hFF, dat_oe_n);
        pin_sel = 0;
        start = 1;
        @(negedge clk_in);
        start = 0;
        repeat (4) @(negedge clk_in);
        chk(0, busy);
        pin_sel = 1;
        for (k = 0; k < 4; k++) begin
            blk = {$urandom, $urandom, $urandom, $urandom};
            resp = {2'h0, 13'($urandom), $urandom, 1'b1};
            word = 38'({$urandom, $urandom});
            dly = k[0] ? 4'h8 : 4'h1;
            rd_q.delete();
            op(md_tab[k], wd_tab[k], 1, 1, 0, 1);
            chk(1, got_d);
            chk({2'b01, word, 8'h01}, cmd_got);
            chk(resp[39:0], resp_got);
            repeat (60) @(negedge clk_in);
            chk(16, rd_q.size());
            for (j = 0; j < rd_q.size(); j++) chk(blk[127-8*j -: 8], rd_q[j]);
        end
        blk = {$urandom, $urandom, $urandom, $urandom};
        wr_idx = 0;
        repeat (30) @(negedge clk_in);
        chk(8, wr_idx);
        chk(0, wr_ready);
        op(`SMH_MODE_MMC, `SMH_WID_4, 1, 0, 1, 1);
        chk(1, got_d);
        chk(blk, wr_got);
        op(`SMH_MODE_SD, `SMH_WID_1, 1, 0, 0, 0);
        chk(1, got_t);
        kind = `SMH_DET_SWITCH;
        @(negedge clk_in);
        sw = 0;
        watch_event;
        chk(1, got_e);
        chk(1, present);
        kind = `SMH_DET_NONE;
        @(negedge clk_in);
        sw = 1;
        watch_event;
        chk(0, got_e);
        @(negedge clk_in);
        kind = `SMH_DET_DAT3;
        watch_event;
        chk(1, got_e);
        stop_test;
    end
endmodule // testbench
`default_nettype wire
